// *** bench/analog_front_model.sv ***
// analog side model: source levels, sample-and-hold, comparator, free-running rc clock
// assumes trial_code and sample_hold come from the converter control on pclk
`timescale 1ns/1ns
module analog_front_model (
    input wire logic pclk,
    input wire logic [5:0] channel_select,
    input wire logic channel_connect,
    input wire adc_pkg::src_t source_kind,
    input wire logic sample_hold,
    input wire logic [9:0] trial_code,
    output logic comparator_in,
    output logic dedicated_rc_clock
);
    import adc_pkg::*;
    logic [9:0] level;
    logic [9:0] held_q;
    logic toggle_q;
    // ground reads zero, other sources a level coded from the channel
    assign level = (source_kind == SRC_GND) ? 10'h000 : {channel_select, 4'h5};
    always @(posedge pclk) begin
        toggle_q <= ~toggle_q;
        if (sample_hold) begin
            held_q <= level;
        end
    end
    // floating input gives no steady answer
    assign comparator_in = channel_connect ? (held_q >= trial_code) : toggle_q;
    initial begin
        toggle_q = 1'b0;
        held_q = 10'h000;
        dedicated_rc_clock = 1'b0;
        forever #115 dedicated_rc_clock = ~dedicated_rc_clock;
    end
endmodule : analog_front_model

// *** bench/tb_adc_config_result.sv ***
// self-checking bench for the converter control over apb
// assumes the analog front model answers the comparator and runs the rc clock
`timescale 1ns/1ns
`include "adc_regs.svh"
module tb_adc_config_result;
    import adc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rc, cmp, conn, nref, sh, busy, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] trig;
    logic [5:0] chan;
    logic [20:0] ain;
    logic [9:0] trial;
    src_t kind;
    pref_t pref;
    int errors, total_checks;
    localparam logic [5:0] src_codes [11] = '{6'h00, 6'h06, 6'h08, 6'h0E, 6'h10, 6'h16, 6'h3C, 6'h3D, 6'h3E,
        6'h3F, 6'h20};
    localparam logic [2:0] src_kinds [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
    localparam logic [5:0] conv_chs [8] = '{6'h02, 6'h3C, 6'h3D, 6'h3E, 6'h3F, 6'h00, 6'h13, 6'h3D};
    adc_config_result #(.LV_PART(1'b0)) u_adc_config_result (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dedicated_rc_clock(rc), .comparator_in(cmp), .auto_trigger_in(trig),
        .channel_select(chan), .source_kind(kind), .channel_connect(conn), .analog_input_enable(ain),
        .positive_ref_select(pref), .neg_ref_pin(nref), .sample_hold(sh), .trial_code(trial),
        .conv_busy(busy), .conv_irq(irq));
    analog_front_model u_analog_front_model (.pclk(pclk), .channel_select(chan), .channel_connect(conn),
        .source_kind(kind), .sample_hold(sh), .trial_code(trial), .comparator_in(cmp), .dedicated_rc_clock(rc));
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rng(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : rng
    // called just after a rising edge; holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                errors++;
                finish_test();
            end
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk($sformatf("reg %h", a), exp, r);
    endtask : rd
    task automatic wait_conv(output int cyc);
        int n;
        n = 0;
        cyc = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk("hold", 32'h1, sh);
        while (busy === 1'b1 && cyc < 5000) begin
            @(posedge pclk);
            cyc++;
        end
        if (n >= 20 || cyc >= 5000) begin
            errors++;
            finish_test();
        end
        repeat (2) @(posedge pclk);
    endtask : wait_conv
    task automatic s_reset;
        logic [31:0] r;
        logic e;
        for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("unmapped_err", 32'h1, e);
        chk("unmapped_data", 32'h0, r);
        chk("chan", 32'h0, chan);
    endtask : s_reset
    task automatic s_refs;
        for (int p = 0; p < 8; p++) begin
            wr(`ADC_OFF_FMT, p[2:0]);
            repeat (2) @(posedge pclk);
            chk("pref", p[1:0], pref);
            chk("nref", p[2], nref);
            rd(`ADC_OFF_FMT, p[2:0]);
        end
    endtask : s_refs
    task automatic s_src;
        for (int i = 0; i < 11; i++) begin
            wr(`ADC_OFF_CHAN, {src_codes[i], 2'h0});
            repeat (2) @(posedge pclk);
            chk("chan", src_codes[i], chan);
            chk("kind", src_kinds[i], kind);
        end
    endtask : s_src
    task automatic s_pins;
        wr(`ADC_OFF_DIR, 32'h000F0F05);
        wr(`ADC_OFF_ASEL, 32'h001E00FF);
        repeat (2) @(posedge pclk);
        chk("ain", 32'h000F0F05 & 32'h001E00FF, ain);
        wr(`ADC_OFF_CHAN, {6'h09, 2'h0});
        repeat (2) @(posedge pclk);
        chk("conn", 32'h0, conn);
        wr(`ADC_OFF_CHAN, {6'h13, 2'h0});
        repeat (2) @(posedge pclk);
        chk("conn", 32'h1, conn);
    endtask : s_pins
    task automatic s_conv(input int cs, input logic [5:0] ch);
        int n;
        logic [9:0] v;
        v = (ch == `ADC_CH_GND) ? 10'h000 : {ch, 4'h5};
        wr(`ADC_OFF_FMT, {cs[0], cs[2:0], 4'h0});
        wr(`ADC_OFF_IRQ, 32'h3);
        wr(`ADC_OFF_CHAN, {ch, 2'h1});
        repeat (8) @(posedge pclk);
        wr(`ADC_OFF_CHAN, {ch, 2'h3});
        wait_conv(n);
        if (cs < 6) rng("conv_len", 22 << cs, (24 << cs) + 3, n);
        else rng("rc_conv_len", 46, 62, n);
        rd(`ADC_OFF_RESH, cs[0] ? v[9:8] : v[9:2]);
        rd(`ADC_OFF_RESL, cs[0] ? v[7:0] : {v[1:0], 6'h00});
        chk("trial", v, trial);
        chk("irq", 32'h1, irq);
        wr(`ADC_OFF_IRQ, 32'h3);
        rd(`ADC_OFF_IRQ, 32'h2);
    endtask : s_conv
    task automatic s_trig;
        int n;
        wr(`ADC_OFF_FMT, 32'h0);
        wr(`ADC_OFF_IRQ, 32'h1);
        wr(`ADC_OFF_TRIG, 32'h3);
        wr(`ADC_OFF_CHAN, {`ADC_CH_DAC, 2'h1});
        trig <= 16'h0020;
        repeat (10) @(posedge pclk);
        chk("busy", 32'h0, busy);
        trig <= 16'h0008;
        wait_conv(n);
        trig <= 16'h0000;
        rng("trig_len", 22, 27, n);
        rd(`ADC_OFF_RESH, {`ADC_CH_DAC, 2'h1});
        rd(`ADC_OFF_IRQ, 32'h1);
        chk("irq", 32'h0, irq);
    endtask : s_trig
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        errors = 0;
        total_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        trig = 16'h0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_reset();
        s_refs();
        s_src();
        s_pins();
        for (int i = 0; i < 8; i++) s_conv(i, conv_chs[i]);
        s_trig();
        finish_test();
    end
endmodule : tb_adc_config_result

// *** rtl/adc_config_result.sv ***
// ten-bit converter control: registers, source and reference steering, bit clock, results
// assumes an APB master on pclk, a comparator answering on pclk and an asynchronous RC clock pin
`timescale 1ns/1ns
`include "adc_regs.svh"

// Behaviour
// - six-bit channel field picks the source fed to sample-and-hold
// - sources: seven pins per port, temperature, DAC, fixed reference, ground
// - two-bit field picks positive reference: pin, supply, 2.048V, 4.096V
// - one bit picks negative reference: pin or ground
// - three-bit field picks conversion clock: system clock /2 to /64, or RC
// - one period per bit; a full conversion lasts 11.5 periods
// - divider clocks follow the system clock; only the RC clock is independent
// - left format: high result register holds result bits 9 to 2
// - left format: low register holds bits 1,0 in 7,6; rest reserved
// - pin is a converter input only with direction and analog bits set
module adc_config_result #(
    parameter bit LV_PART = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dedicated_rc_clock,
    input wire logic comparator_in,
    input wire logic [15:0] auto_trigger_in,
    output logic [5:0] channel_select,
    output adc_pkg::src_t source_kind,
    output logic channel_connect,
    output logic [20:0] analog_input_enable,
    output adc_pkg::pref_t positive_ref_select,
    output logic neg_ref_pin,
    output logic sample_hold,
    output logic [9:0] trial_code,
    output logic conv_busy,
    output logic conv_irq
);
    import adc_pkg::*;

    conv_if cv ();

    logic [5:0] chan_q;
    logic on_q;
    logic go_q;
    logic [7:0] fmt_q;
    logic [3:0] trig_q;
    logic [7:0] resh_q;
    logic [7:0] resl_q;
    logic flag_q;
    logic ien_q;
    logic [20:0] dir_q;
    logic [20:0] asel_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic hit_d;
    logic wr_fire;
    logic wr_chan;
    logic wr_fmt;
    logic wr_irq;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic trig_prev_q;
    logic trig_edge;
    logic start;
    logic rc_mode;
    logic [4:0] div_lim;
    logic [4:0] div_q;
    logic [5:0] gap_q;
    logic is_pin;
    logic [4:0] pin_idx;
    src_t src_d;
    logic connect_d;
    pref_t pref_d;
    logic [5:0] chan_sel_q;
    src_t src_q;
    logic connect_q;
    logic [20:0] ain_q;
    pref_t pref_q;
    logic nref_q;
    logic busy_q;
    logic irq_q;

    conv_sequencer u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .cv(cv.seq)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign channel_select = chan_sel_q;
    assign source_kind = src_q;
    assign channel_connect = connect_q;
    assign analog_input_enable = ain_q;
    assign positive_ref_select = pref_q;
    assign neg_ref_pin = nref_q;
    assign sample_hold = cv.sample;
    assign trial_code = cv.trial;
    assign conv_busy = busy_q;
    assign conv_irq = irq_q;

    // APB: one wait state, write and read data at the edge pready is seen
    assign wr_fire = psel && penable && pwrite && pready_q && !pslverr_q;
    assign wr_chan = wr_fire && (paddr == `ADC_OFF_CHAN);
    assign wr_fmt = wr_fire && (paddr == `ADC_OFF_FMT);
    assign wr_irq = wr_fire && (paddr == `ADC_OFF_IRQ);

    always_comb begin
        rd_d = 32'h00000000;
        hit_d = 1'b1;
        case (paddr)
            `ADC_OFF_CHAN: rd_d[7:0] = {chan_q, go_q, on_q};
            `ADC_OFF_FMT: rd_d[7:0] = fmt_q;
            `ADC_OFF_TRIG: rd_d[3:0] = trig_q;
            `ADC_OFF_RESH: rd_d[7:0] = resh_q;
            `ADC_OFF_RESL: rd_d[7:0] = resl_q;
            `ADC_OFF_IRQ: rd_d[1:0] = {ien_q, flag_q};
            `ADC_OFF_DIR: rd_d[20:0] = dir_q;
            `ADC_OFF_ASEL: rd_d[20:0] = asel_q;
            default: hit_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !hit_d;
            prdata_q <= (pwrite || !hit_d) ? 32'h00000000 : rd_d;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_q <= `ADC_RST_CHAN;
            on_q <= 1'b0;
            fmt_q <= `ADC_RST_FMT;
            trig_q <= `ADC_RST_TRIG;
            dir_q <= `ADC_RST_PINS;
            asel_q <= `ADC_RST_PINS;
            ien_q <= 1'b0;
        end else if (wr_fire) begin
            if (wr_chan) begin
                chan_q <= pwdata[`ADC_CHAN_MSB:`ADC_CHAN_LSB];
                on_q <= pwdata[`ADC_ON_BIT];
            end
            if (wr_fmt) begin
                fmt_q <= pwdata[7:0];
            end
            if (paddr == `ADC_OFF_TRIG) begin
                trig_q <= pwdata[3:0];
            end
            if (paddr == `ADC_OFF_DIR) begin
                dir_q <= pwdata[20:0];
            end
            if (paddr == `ADC_OFF_ASEL) begin
                asel_q <= pwdata[20:0];
            end
            if (wr_irq) begin
                ien_q <= pwdata[`ADC_IEN_BIT];
            end
        end
    end

    // RC pin synchroniser; third stage only for its edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
        end else begin
            rc_s1 <= dedicated_rc_clock;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
        end
    end
    // comparator answers on pclk; a synchroniser would outlast a two-clock bit period
    assign cv.cmp = comparator_in;

    // start: go bit written with enable set, or edge of the chosen trigger
    assign trig_edge = (trig_q != 4'h0) && auto_trigger_in[trig_q] && !trig_prev_q;
    assign start = (on_q || (wr_chan && pwdata[`ADC_ON_BIT])) && !go_q && !cv.busy &&
                   ((wr_chan && pwdata[`ADC_GO_BIT] && pwdata[`ADC_ON_BIT]) || (trig_edge && on_q));
    assign cv.start = start;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_q <= 1'b0;
            go_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            trig_prev_q <= auto_trigger_in[trig_q];
            if (start) begin
                go_q <= 1'b1;
            end else if (cv.done) begin
                go_q <= 1'b0;
            end
            busy_q <= start || (go_q && !cv.done);
        end
    end

    // bit clock: half periods of 1 to 32 pclk, or RC edges
    assign rc_mode = fmt_q[`ADC_CS_MSB] && fmt_q[`ADC_CS_MSB - 1];
    assign div_lim = 5'((6'h01 << fmt_q[`ADC_CS_MSB:`ADC_CS_LSB]) - 6'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 5'h00;
        end else if (rc_mode || !cv.busy || div_q == div_lim) begin
            div_q <= 5'h00;
        end else begin
            div_q <= div_q + 5'h01;
        end
    end

    // dividers track pclk; RC edges are independent of it
    assign cv.half_tick = rc_mode ? (rc_s2 != rc_s3) : (cv.busy && div_q == div_lim);

    // source decode and pin qualification
    assign is_pin = !chan_q[5] && (chan_q[4:3] != 2'h3) && (chan_q[2:0] != 3'h7);
    assign pin_idx = 5'({3'h0, chan_q[4:3]} * 5'h07 + {2'h0, chan_q[2:0]});

    always_comb begin
        src_d = SRC_GND;
        if (is_pin) begin
            src_d = SRC_PIN;
        end else if (chan_q == `ADC_CH_TEMP) begin
            src_d = SRC_TEMP;
        end else if (chan_q == `ADC_CH_DAC) begin
            src_d = SRC_DAC;
        end else if (chan_q == `ADC_CH_FIXREF) begin
            src_d = SRC_FIXREF;
        end
    end

    assign connect_d = is_pin ? (dir_q[pin_idx] && asel_q[pin_idx]) : 1'b1;

    // upper internal reference is missing on low-voltage parts: supply instead
    always_comb begin
        pref_d = pref_t'(fmt_q[`ADC_PREF_MSB:`ADC_PREF_LSB]);
        if (LV_PART && pref_d == PREF_INT4V) begin
            pref_d = PREF_SUPPLY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_sel_q <= `ADC_RST_CHAN;
            src_q <= SRC_PIN;
            connect_q <= 1'b0;
            ain_q <= `ADC_RST_PINS;
            pref_q <= PREF_PIN;
            nref_q <= 1'b0;
        end else begin
            chan_sel_q <= chan_q;
            src_q <= src_d;
            connect_q <= connect_d;
            ain_q <= dir_q & asel_q;
            pref_q <= pref_d;
            nref_q <= fmt_q[`ADC_NREF_BIT];
        end
    end

    // results and done flag; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resh_q <= `ADC_RST_RES;
            resl_q <= `ADC_RST_RES;
        end else if (cv.done) begin
            if (!fmt_q[`ADC_FM_BIT]) begin
                resh_q <= cv.result[9:2];
                resl_q <= {cv.result[1:0], 6'h00};
            end else begin
                resh_q <= {6'h00, cv.result[9:8]};
                resl_q <= cv.result[7:0];
            end
        end else if (wr_fire && paddr == `ADC_OFF_RESH) begin
            resh_q <= pwdata[7:0];
        end else if (wr_fire && paddr == `ADC_OFF_RESL) begin
            resl_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (cv.done) begin
                flag_q <= 1'b1;
            end else if (wr_irq && pwdata[`ADC_FLAG_BIT]) begin
                flag_q <= 1'b0;
            end
            irq_q <= (cv.done || (flag_q && !(wr_irq && pwdata[`ADC_FLAG_BIT]))) &&
                     (wr_irq ? pwdata[`ADC_IEN_BIT] : ien_q);
        end
    end

    // helper: cycles between half ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 6'h00;
        end else if (!cv.busy || rc_mode || cv.half_tick) begin
            gap_q <= 6'h00;
        end else begin
            gap_q <= gap_q + 6'h01;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_done;
        cv.done && !fmt_q[`ADC_FM_BIT];
    endsequence

    sequence s_done_en;
        cv.done && ien_q && !wr_irq;
    endsequence

    property p_chan;
        wr_chan |-> ##2 channel_select == $past(pwdata[7:2], 2);
    endproperty
    a_chan: assert property (p_chan) else $error("channel select not applied");

    property p_src;
        (channel_select == `ADC_CH_DAC) |-> (source_kind == SRC_DAC) && channel_connect;
    endproperty
    a_src: assert property (p_src) else $error("DAC source not decoded");

    property p_pref;
        (wr_fmt && !LV_PART) |-> ##2 positive_ref_select == $past(pwdata[1:0], 2);
    endproperty
    a_pref: assert property (p_pref) else $error("positive reference not applied");

    property p_nref;
        wr_fmt |-> ##2 neg_ref_pin == $past(pwdata[2], 2);
    endproperty
    a_nref: assert property (p_nref) else $error("negative reference not applied");

    property p_div;
        (cv.half_tick && !rc_mode && $past(cv.busy) && $stable(fmt_q)) |-> gap_q == div_lim;
    endproperty
    a_div: assert property (p_div) else $error("half period length wrong for divider");

    property p_rc;
        (rc_mode && rc_s2 == rc_s3) |-> !cv.half_tick;
    endproperty
    a_rc: assert property (p_rc) else $error("RC mode ticked without RC edge");

    property p_hi;
        s_done |=> resh_q == $past(cv.result[9:2]);
    endproperty
    a_hi: assert property (p_hi) else $error("high result layout wrong");

    property p_lo;
        s_done |=> resl_q == {$past(cv.result[1:0]), 6'h00};
    endproperty
    a_lo: assert property (p_lo) else $error("low result layout wrong");

    property p_pin;
        (source_kind == SRC_PIN && channel_connect) |-> (analog_input_enable != 21'h000000);
    endproperty
    a_pin: assert property (p_pin) else $error("pin connected without analog enable");

    property p_irq;
        s_done_en |=> flag_q && conv_irq && !conv_busy;
    endproperty
    a_irq: assert property (p_irq) else $error("completion did not flag or interrupt");
endmodule : adc_config_result

// *** rtl/adc_pkg.sv ***
// types shared by the converter control and its bit sequencer
// assumes nothing of its surroundings
package adc_pkg;
    typedef enum logic [1:0] {
        PREF_PIN = 2'b00,
        PREF_SUPPLY = 2'b01,
        PREF_INT2V = 2'b10,
        PREF_INT4V = 2'b11
    } pref_t;
    typedef enum logic [2:0] {
        SRC_PIN = 3'b000,
        SRC_TEMP = 3'b001,
        SRC_DAC = 3'b010,
        SRC_FIXREF = 3'b011,
        SRC_GND = 3'b100
    } src_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ACQ = 2'b01,
        S_BIT = 2'b10
    } seq_state_t;
endpackage : adc_pkg

// *** rtl/adc_regs.svh ***
// register map, field positions, reset values and timing counts of the converter control
// assumes byte addresses on an APB bus with one 32-bit word per register
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH
`define ADC_OFF_CHAN 8'h00
`define ADC_OFF_FMT 8'h04
`define ADC_OFF_TRIG 8'h08
`define ADC_OFF_RESH 8'h0C
`define ADC_OFF_RESL 8'h10
`define ADC_OFF_IRQ 8'h14
`define ADC_OFF_DIR 8'h18
`define ADC_OFF_ASEL 8'h1C
`define ADC_ON_BIT 0
`define ADC_GO_BIT 1
`define ADC_CHAN_LSB 2
`define ADC_CHAN_MSB 7
`define ADC_PREF_LSB 0
`define ADC_PREF_MSB 1
`define ADC_NREF_BIT 2
`define ADC_CS_LSB 4
`define ADC_CS_MSB 6
`define ADC_FM_BIT 7
`define ADC_FLAG_BIT 0
`define ADC_IEN_BIT 1
`define ADC_RST_CHAN 6'h00
`define ADC_RST_FMT 8'h00
`define ADC_RST_TRIG 4'h0
`define ADC_RST_RES 8'h00
`define ADC_RST_PINS 21'h000000
`define ADC_PINS 21
`define ADC_CH_TEMP 6'h3C
`define ADC_CH_DAC 6'h3D
`define ADC_CH_FIXREF 6'h3E
`define ADC_CH_GND 6'h3F
`define ADC_ACQ_HALF 5'h03
`define ADC_CONV_HALF 5'h17
`endif

// *** rtl/conv_if.sv ***
// handshake between the register side and the bit sequencer
// assumes both ends run on pclk
`timescale 1ns/1ns
interface conv_if;
    logic start;
    logic half_tick;
    logic cmp;
    logic busy;
    logic sample;
    logic done;
    logic [9:0] trial;
    logic [9:0] result;
    modport ctrl (output start, output half_tick, output cmp,
                  input busy, input sample, input done, input trial, input result);
    modport seq (input start, input half_tick, input cmp,
                 output busy, output sample, output done, output trial, output result);
endinterface : conv_if

// *** rtl/conv_sequencer.sv ***
// successive-approximation sequencer counting half bit periods
// assumes half_tick pulses on pclk and a comparator level valid on pclk
`timescale 1ns/1ns
`include "adc_regs.svh"
module conv_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    conv_if.seq cv
);
    import adc_pkg::*;

    seq_state_t state_q;
    logic [4:0] half_q;
    logic [3:0] bit_q;
    logic [9:0] trial_q;
    logic sample_q;
    logic done_q;
    logic [9:0] result_q;
    logic [4:0] span_q;

    assign cv.busy = (state_q != S_IDLE);
    assign cv.sample = sample_q;
    assign cv.done = done_q;
    assign cv.trial = trial_q;
    assign cv.result = result_q;

    // 3 half periods of sampling, then 2 per bit: 23 in all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            half_q <= 5'h00;
            bit_q <= 4'h0;
            trial_q <= 10'h000;
            sample_q <= 1'b0;
            done_q <= 1'b0;
            result_q <= 10'h000;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                S_IDLE: begin
                    if (cv.start) begin
                        state_q <= S_ACQ;
                        half_q <= 5'h00;
                        sample_q <= 1'b1;
                    end
                end
                S_ACQ: begin
                    if (cv.half_tick) begin
                        half_q <= half_q + 5'h01;
                        if (half_q == `ADC_ACQ_HALF - 5'h01) begin
                            state_q <= S_BIT;
                            sample_q <= 1'b0;
                            trial_q <= 10'h200;
                            bit_q <= 4'h9;
                        end
                    end
                end
                S_BIT: begin
                    if (cv.half_tick) begin
                        half_q <= half_q + 5'h01;
                        // decision at the end of each bit period
                        if (!half_q[0]) begin
                            if (!cv.cmp) begin
                                trial_q[bit_q] <= 1'b0;
                            end
                            if (bit_q == 4'h0) begin
                                result_q <= {trial_q[9:1], cv.cmp};
                                done_q <= 1'b1;
                                state_q <= S_IDLE;
                            end else begin
                                trial_q[4'(bit_q - 4'h1)] <= 1'b1;
                                bit_q <= bit_q - 4'h1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // helper: half periods since start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            span_q <= 5'h00;
        end else if (cv.start && !cv.busy) begin
            span_q <= 5'h00;
        end else if (cv.busy && cv.half_tick) begin
            span_q <= span_q + 5'h01;
        end
    end

    sequence s_finish;
        $rose(done_q);
    endsequence

    property p_len;
        @(posedge pclk) disable iff (!presetn)
        s_finish |-> (span_q == `ADC_CONV_HALF) && !cv.busy;
    endproperty
    a_len: assert property (p_len) else $error("conversion did not last 11.5 bit periods");
endmodule : conv_sequencer
